/* File: common/psr_defines.vh */
// constants for the peripheral soft reset timer
// Behaviour
// - every peripheral group has a software trigger bit
// - trigger holds chosen reset low for duration
// - duration register 16-bit read/write, resets zero
// - countdown zero releases reset, clears triggers
// - group four resets both audio ports, uart, spi
// - write one starts reset, zero ignored
// - trigger bit reads live reset state
// - trigger bit layout fixed, reserved bits read zero
`ifndef PSR_DEFINES_VH
`define PSR_DEFINES_VH
`define PSR_DUR_IDX        16'h1c04
`define PSR_TRIG_IDX       16'h1c05
`define PSR_DUR_ADDR       18'h07010
`define PSR_TRIG_ADDR      18'h07014
`define PSR_DUR_RESET      16'h0000
`define PSR_DUR_MIN        16'h0008
`define PSR_CNT_LAST       16'h0001
`define PSR_CNT_ZERO       16'h0000
`define PSR_TRIG_MASK      8'hbf
`define PSR_BIT_I2C        0
`define PSR_BIT_GRP1       1
`define PSR_BIT_USB_LO     2
`define PSR_BIT_USB_HI     3
`define PSR_BIT_DMA        4
`define PSR_BIT_GRP3       5
`define PSR_BIT_GRP4       7
`endif

/* File: rtl/psr_timer.v */
// peripheral soft reset timer with apb register access
//
// The implementer's own choice: the APB register port.
`include "psr_defines.vh"
module psr_timer (
  // apb
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // peripheral resets, active low
  output reg         i2c_rst_n,
  output reg         group_one_rst_n,
  output reg         usb_rst_n,
  output reg         dma_rst_n,
  output reg         group_three_rst_n,
  output reg         group_four_rst_n
);

  // a write to the trigger register starts a countdown from the duration
  // register; every line whose trigger bit is set stays low until the
  // countdown ends, and all bits clear together at that point
  // limitation: nothing stops the bus from touching a peripheral while it
  // is held in reset; software has to wait on its own

  // register state
  reg  [15:0] soft_reset_duration_reg;
  reg  [15:0] soft_reset_duration_next;
  reg  [7:0]  trig_reg;
  reg  [7:0]  trig_next;
  reg  [15:0] count_reg;
  reg  [15:0] count_next;

  // bus answer next values
  reg  [31:0] prdata_next;
  reg         pready_next;
  reg         pslverr_next;

  // reset line next values
  reg         i2c_rst_n_next;
  reg         group_one_rst_n_next;
  reg         usb_rst_n_next;
  reg         dma_rst_n_next;
  reg         group_three_rst_n_next;
  reg         group_four_rst_n_next;

  // decoded bus phases and targets
  wire        setup;
  wire        access;
  wire        wr;
  wire        rd;
  reg         hit_dur;
  reg         hit_trig;
  reg         hit_none;
  wire [7:0]  set_bits;
  wire [7:0]  usb_mask;
  wire        trig_busy;
  wire        count_last;

  // exact match of a bus address against a register byte address
  function is_addr;
    input [31:0] a;
    input [17:0] b;
    begin
      is_addr = (a[31:18] == 14'h0000) && (a[17:0] == b);
    end
  endfunction

  // a reset line is asserted (low) while any of its trigger bits is set
  function line_n;
    input [7:0] bits;
    input [7:0] sel;
    begin
      line_n = ~(|(bits & sel));
    end
  endfunction

  // one-hot select mask for a trigger bit position
  function [7:0] bit_mask;
    input [2:0] pos;
    begin
      bit_mask = 8'h01 << pos;
    end
  endfunction

  // read data for a decoded register; anything else reads zero
  function [31:0] read_word;
    input        sel_dur;
    input        sel_trig;
    input [15:0] dur;
    input [7:0]  trig;
    begin
      if (sel_dur) begin
        read_word = {16'h0000, dur};
      end else if (sel_trig) begin
        read_word = {24'h000000, trig};
      end else begin
        read_word = 32'h00000000;
      end
    end
  endfunction

  // one step of the countdown; never wraps below zero
  function [15:0] count_step;
    input [15:0] c;
    begin
      if (c > `PSR_CNT_ZERO) begin
        count_step = c - `PSR_CNT_LAST;
      end else begin
        count_step = `PSR_CNT_ZERO;
      end
    end
  endfunction

  assign setup  = psel & ~penable;
  // the access phase is the cycle in which pready stands high
  assign access = psel & penable & pready;
  // writes land only at the edge that completes the access phase
  assign wr     = access & pwrite;
  assign rd     = setup & ~pwrite;

  // address decode; unmapped addresses answer with an error
  always @* begin
    hit_dur  = 1'b0;
    hit_trig = 1'b0;
    hit_none = 1'b0;
    if (is_addr(paddr, `PSR_DUR_ADDR)) begin
      hit_dur = 1'b1;
    end else if (is_addr(paddr, `PSR_TRIG_ADDR)) begin
      hit_trig = 1'b1;
    end else begin
      hit_none = 1'b1;
    end
  end

  // usb field is two bits wide; either one starts it
  assign set_bits   = (wr && hit_trig) ? (pwdata[7:0] & `PSR_TRIG_MASK) : 8'h00;
  assign usb_mask   = bit_mask(`PSR_BIT_USB_LO) | bit_mask(`PSR_BIT_USB_HI);
  assign trig_busy  = (trig_reg != 8'h00);
  assign count_last = (count_reg <= `PSR_CNT_LAST);

  // apb answer: one wait-free access phase after every setup cycle;
  // read data is captured at the setup edge so it stands with pready
  always @* begin
    pready_next  = 1'b0;
    pslverr_next = 1'b0;
    prdata_next  = 32'h00000000;
    if (setup) begin
      pready_next  = 1'b1;
      pslverr_next = hit_none;
    end
    if (rd) begin
      prdata_next = read_word(hit_dur, hit_trig, soft_reset_duration_reg, trig_reg);
    end
  end

  // duration register, software owned, never touched by the countdown
  always @* begin
    soft_reset_duration_next = soft_reset_duration_reg;
    if (wr && hit_dur) begin
      soft_reset_duration_next = pwdata[15:0];
    end
  end

  // a new trigger wins over the clear at the end of a countdown
  always @* begin
    trig_next  = trig_reg;
    count_next = count_reg;
    if (set_bits != 8'h00) begin
      trig_next  = trig_reg | set_bits;
      count_next = soft_reset_duration_reg;
    end else if (trig_busy) begin
      if (count_last) begin
        // a zero duration still yields one cycle of reset
        trig_next  = 8'h00;
        count_next = `PSR_CNT_ZERO;
      end else begin
        count_next = count_step(count_reg);
      end
    end
  end

  // lines follow the next trigger state so they fall and rise with the bits
  always @* begin
    i2c_rst_n_next         = line_n(trig_next, bit_mask(`PSR_BIT_I2C));
    group_one_rst_n_next   = line_n(trig_next, bit_mask(`PSR_BIT_GRP1));
    usb_rst_n_next         = line_n(trig_next, usb_mask);
    dma_rst_n_next         = line_n(trig_next, bit_mask(`PSR_BIT_DMA));
    group_three_rst_n_next = line_n(trig_next, bit_mask(`PSR_BIT_GRP3));
    group_four_rst_n_next  = line_n(trig_next, bit_mask(`PSR_BIT_GRP4));
  end

  // bus ready flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= pready_next;
    end
  end

  // bus error flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= pslverr_next;
    end
  end

  // read data flop, zero outside the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else begin
      prdata <= prdata_next;
    end
  end

  // duration register flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_reset_duration_reg <= `PSR_DUR_RESET;
    end else begin
      soft_reset_duration_reg <= soft_reset_duration_next;
    end
  end

  // trigger bits flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_reg <= 8'h00;
    end else begin
      trig_reg <= trig_next;
    end
  end

  // countdown flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= `PSR_CNT_ZERO;
    end else begin
      count_reg <= count_next;
    end
  end

  // i2c reset line
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      i2c_rst_n <= 1'b1;
    end else begin
      i2c_rst_n <= i2c_rst_n_next;
    end
  end

  // group one reset line
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group_one_rst_n <= 1'b1;
    end else begin
      group_one_rst_n <= group_one_rst_n_next;
    end
  end

  // usb reset line
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usb_rst_n <= 1'b1;
    end else begin
      usb_rst_n <= usb_rst_n_next;
    end
  end

  // dma reset line
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_rst_n <= 1'b1;
    end else begin
      dma_rst_n <= dma_rst_n_next;
    end
  end

  // group three reset line
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group_three_rst_n <= 1'b1;
    end else begin
      group_three_rst_n <= group_three_rst_n_next;
    end
  end

  // group four reset line, shared by both audio ports, uart and spi
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group_four_rst_n <= 1'b1;
    end else begin
      group_four_rst_n <= group_four_rst_n_next;
    end
  end

endmodule // psr_timer

/* File: verif/psr_periph_model.sv */
// peripheral side: measures how long the reset lines stay low
module psr_periph_model (
  input  wire logic        pclk,
  input  wire logic [5:0]  rn,
  output logic      [16:0] held
);
  timeunit 1ns;
  timeprecision 1ns;
  logic idle = 1'b1;
  initial held = 17'h0;
  // stays untouched while all lines are high
  always @(posedge pclk) begin
    held <= (&rn) ? held : (idle ? 17'h1 : held + 17'h1);
    idle <= &rn;
  end
endmodule // psr_periph_model

/* File: verif/psr_timer_checker.sv */
// port assertions for the peripheral soft reset timer
module psr_timer_checker (
  input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [31:0] paddr, pwdata, prdata,
  input wire logic        i2c_rst_n, usb_rst_n, dma_rst_n, group_four_rst_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire su = psel & ~penable;
  wire tw = psel & penable & pready & pwrite & (paddr == 32'h7014);
  wire rt = pready & ~pwrite & (paddr == 32'h7014);
  chk_ready_next: assert property (su |=> pready) else $error("no ready");
  chk_grp4_low: assert property (tw && pwdata[7] |=> !group_four_rst_n) else $error("no rst");
  chk_zero_keeps:
    assert property (tw && !pwdata[0] && i2c_rst_n |=> i2c_rst_n) else $error("bad rst");
  chk_read_live:
    assert property (rt |-> prdata[7] == !$past(group_four_rst_n)) else $error("bad state");
  chk_res_zero:
    assert property (rt |-> prdata[31:8] == 24'h0 && !prdata[6]) else $error("reserved");
  chk_free_all:
    assert property ($rose(group_four_rst_n) |-> i2c_rst_n && usb_rst_n && dma_rst_n)
    else $error("partial");
  chk_dur_top:
    assert property (pready && !pwrite && paddr == 32'h7010 |-> prdata[31:16] == 16'h0)
    else $error("dur");
  chk_bad_addr: assert property (su && paddr == 32'h7018 |=> pslverr) else $error("no err");
endmodule // psr_timer_checker

/* File: verif/tb.sv */
// testbench for the peripheral soft reset timer
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0, presetn, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, r;
  logic [5:0] rn;
  logic [16:0] held;
  int fail_count = 0, n_compared = 0;
  psr_timer psr_timer_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .i2c_rst_n(rn[0]), .group_one_rst_n(rn[1]), .usb_rst_n(rn[2]),
    .dma_rst_n(rn[3]), .group_three_rst_n(rn[4]), .group_four_rst_n(rn[5]));
  psr_periph_model psr_periph_model_inst (.pclk, .rn, .held);
  task chk(input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [31:0] a, d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    {psel, penable} <= 2'b00;
  endtask
  task test_done;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task s_regs;
    apb(1'b0, 32'h7010, 32'h0);
    chk(r, 32'h0);
    apb(1'b1, 32'h7010, 32'hffffffff);
    apb(1'b0, 32'h7010, 32'h0);
    chk(r, 32'hffff);
    apb(1'b1, 32'h7014, 32'hffffff40);
    apb(1'b0, 32'h7014, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, 32'h7018, 32'h0);
  endtask
  // a second trigger t2 lands three cycles after t1 and restarts the count
  task s_pulse(input logic [31:0] t1, t2, input logic [16:0] len);
    apb(1'b1, 32'h7010, 32'h8);
    apb(1'b1, 32'h7014, t1);
    if (t2 != 32'h0) apb(1'b1, 32'h7014, t2);
    apb(1'b0, 32'h7014, 32'h0);
    chk(r, t1 | t2);
    repeat (12) apb(1'b0, 32'h7014, 32'h0);
    chk(r, 32'h0);
    chk({15'h0, held}, {15'h0, len});
    apb(1'b0, 32'h7010, 32'h0);
    chk(r, 32'h8);
  endtask
  initial forever #50 pclk = ~pclk;
  initial begin
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    s_regs;
    for (int i = 0; i < 8; i++) if (i != 6) s_pulse(32'h1 << i, 32'h0, 17'h8);
    s_pulse(32'h1, 32'h80, 17'hb);
    test_done;
  end
  initial begin
    repeat (4000) @(posedge pclk);
    fail_count++;
    test_done;
  end
endmodule // tb
bind psr_timer psr_timer_checker psr_timer_checker_inst (.*);
